/* pkg/sfd_pkg.sv */
/*
 * sfd_pkg: opcodes, status bit layout, frame lengths and decoder phases
 * for the serial flash instruction decoder.
 * assumes: referenced through sfd_pkg::name by the decoder and the bench only.
 */
package sfd_pkg;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_WR_STATUS = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_DUAL_READ = 8'h3B;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
  localparam logic [7:0] OP_RELEASE_ID = 8'hAB;
  localparam logic [7:0] OP_MAKER_ID = 8'h90;
  localparam logic [7:0] OP_JEDEC_ID = 8'h9F;

  // ----------------------------------------------------------------
  // status register layout
  // ----------------------------------------------------------------
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_WEL_BIT = 1;
  localparam int unsigned ST_BP_LSB = 2;
  localparam int unsigned ST_TB_BIT = 5;
  localparam int unsigned ST_LOCK_BIT = 7;
  localparam logic [7:0] ST_WRITABLE_MASK = 8'hBC;
  localparam logic [7:0] ST_NV_RESET = 8'h00;

  // ----------------------------------------------------------------
  // frame lengths and fill values
  // ----------------------------------------------------------------
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam logic [1:0] ID_DUMMY_LAST = 2'h2;
  localparam logic [1:0] JEDEC_LAST = 2'h2;
  localparam logic [7:0] UNDERRUN_BYTE = 8'hFF;
  localparam int unsigned READ_FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_OPCODE,
    PH_ADDR,
    PH_DUMMY,
    PH_DATA_IN,
    PH_DATA_OUT,
    PH_WAIT,
    PH_IGNORE
  } sfd_phase_t;

endpackage

/* logic/sfd_fifo.sv */
/*
 * sfd_fifo: small synchronous FIFO with valid/ready on both sides.
 * assumes: one clock; i_flush empties it in one cycle.
 */
`timescale 1ns/1ps
module sfd_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
  } sfd_fifo_state_t;

  sfd_fifo_state_t s_r;
  sfd_fifo_state_t s_nxt;
  logic push;
  logic pop;

  assign o_in_ready = (s_r.count != (PW+1)'(DEPTH));
  assign o_out_valid = (s_r.count != '0);
  assign o_out_data = s_r.mem[s_r.rd_ptr];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always_comb begin
    s_nxt = s_r;
    if (i_flush) begin
      s_nxt.wr_ptr = '0;
      s_nxt.rd_ptr = '0;
      s_nxt.count = '0;
    end else begin
      if (push) begin
        s_nxt.mem[s_r.wr_ptr] = i_in_data;
        s_nxt.wr_ptr = (s_r.wr_ptr == PW'(DEPTH - 1)) ? '0 : s_r.wr_ptr + 1'b1;
      end
      if (pop) begin
        s_nxt.rd_ptr = (s_r.rd_ptr == PW'(DEPTH - 1)) ? '0 : s_r.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        s_nxt.count = s_r.count + 1'b1;
      end else if (pop && !push) begin
        s_nxt.count = s_r.count - 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

/* logic/sfd_tx_shift.sv */
/*
 * sfd_tx_shift: output shifter, one bit (or two in dual mode) per step,
 * most significant first; takes a new byte when a byte boundary is hit.
 * assumes: i_step marks a serial clock falling edge inside a frame.
 */
`timescale 1ns/1ps
module sfd_tx_shift (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_restart,
  input wire logic i_step,
  input wire logic i_dual,
  input wire logic [7:0] i_byte,
  output logic o_take,
  output logic o_do,
  output logic o_dio
);
  typedef struct packed {
    logic [2:0] cnt;
    logic [7:0] sh;
    logic do_bit;
    logic dio_bit;
  } sfd_tx_state_t;

  sfd_tx_state_t s_r;
  sfd_tx_state_t s_nxt;
  logic [7:0] data;

  assign o_take = i_step & (s_r.cnt == '0);
  assign o_do = s_r.do_bit;
  assign o_dio = s_r.dio_bit;

  always_comb begin
    s_nxt = s_r;
    data = o_take ? i_byte : s_r.sh;
    if (i_restart) begin
      s_nxt.cnt = '0;
    end else if (i_step) begin
      // msb first; dual puts odd bits on do, even on dio
      s_nxt.do_bit = data[7];
      if (i_dual) begin
        s_nxt.dio_bit = data[6];
        s_nxt.sh = {data[5:0], 2'b00};
        s_nxt.cnt = s_r.cnt + 3'h2;
      end else begin
        s_nxt.sh = {data[6:0], 1'b0};
        s_nxt.cnt = s_r.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

/* logic/sfd_decoder.sv */
/*
 * sfd_decoder: instruction front end of a serial flash. Frames opcodes,
 * addresses, dummy and data bytes from the serial pins, keeps the status
 * register, streams status, id and array read data back out.
 * assumes: serial pins sampled synchronously on i_sys_clk, serial clock
 * well below half of it; array side answers i_cycle_done after exec.
 */
`timescale 1ns/1ps
module sfd_decoder #(
  parameter logic [7:0] DEVICE_ID = 8'h5A,
  parameter logic [7:0] MAKER_ID = 8'hA5,
  parameter logic [7:0] MEM_TYPE = 8'h3C,
  parameter logic [7:0] MEM_CAPACITY = 8'h14,
  parameter int unsigned FIFO_DEPTH = sfd_pkg::READ_FIFO_DEPTH
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_serial_data_in,
  input wire logic i_wp_n,
  output logic o_serial_data_out,
  output logic o_serial_data_out_oe_n,
  output logic o_serial_data_io_out,
  output logic o_serial_data_io_oe_n,
  input wire logic i_cycle_done,
  output logic o_exec,
  output logic [7:0] o_exec_op,
  output logic [23:0] o_exec_addr,
  output logic o_wr_valid,
  output logic [7:0] o_wr_data,
  output logic [23:0] o_wr_addr,
  output logic o_rd_stream,
  output logic [23:0] o_rd_addr,
  input wire logic i_rd_valid,
  output logic o_rd_ready,
  input wire logic [7:0] i_rd_data,
  output logic [7:0] o_status,
  output logic o_power_down
);
  typedef struct packed {
    sfd_pkg::sfd_phase_t phase;
    logic sclk_d;
    logic cs_n_d;
    logic [2:0] bit_cnt;
    logic [1:0] byte_cnt;
    logic [7:0] shift;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic ready_exec;
    logic [7:0] new_status;
    logic write_enable_latch;
    logic busy;
    logic status_lock_bit;
    logic tb;
    logic [2:0] bp;
    logic pdown;
    logic rd_stream;
    logic dual;
    logic [1:0] id_sel;
    logic exec;
    logic [7:0] exec_op;
    logic [23:0] exec_addr;
    logic wr_valid;
    logic [7:0] wr_data;
    logic [23:0] wr_addr;
  } sfd_dec_state_t;

  sfd_dec_state_t s_r;
  sfd_dec_state_t s_nxt;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic [7:0] byte_in;
  logic [7:0] status;
  logic [7:0] tx_byte;
  logic tx_take;
  logic tx_step;
  logic fifo_valid;
  logic fifo_pop;
  logic fifo_in_ready;
  logic [7:0] fifo_data;
  logic out_phase;

  // ----------------------------------------------------------------
  // pin edges
  // ----------------------------------------------------------------
  assign cs_fall = ~i_cs_n & s_r.cs_n_d;
  assign cs_rise = i_cs_n & ~s_r.cs_n_d;
  assign sclk_rise = i_sclk & ~s_r.sclk_d & ~i_cs_n;
  assign sclk_fall = ~i_sclk & s_r.sclk_d & ~i_cs_n;
  assign byte_in = {s_r.shift[6:0], i_serial_data_in};
  assign out_phase = (s_r.phase == sfd_pkg::PH_DATA_OUT) & ~i_cs_n;
  assign tx_step = sclk_fall & (s_r.phase == sfd_pkg::PH_DATA_OUT);

  // ----------------------------------------------------------------
  // status register image
  // ----------------------------------------------------------------
  always_comb begin
    status = '0;
    status[sfd_pkg::ST_BUSY_BIT] = s_r.busy;
    status[sfd_pkg::ST_WEL_BIT] = s_r.write_enable_latch;
    status[sfd_pkg::ST_BP_LSB +: 3] = s_r.bp;
    status[sfd_pkg::ST_TB_BIT] = s_r.tb;
    status[sfd_pkg::ST_LOCK_BIT] = s_r.status_lock_bit;
  end

  // ----------------------------------------------------------------
  // output byte source
  // ----------------------------------------------------------------
  always_comb begin
    tx_byte = sfd_pkg::UNDERRUN_BYTE;
    case (s_r.opcode)
      sfd_pkg::OP_RD_STATUS: tx_byte = status; // fresh each byte
      sfd_pkg::OP_RELEASE_ID: tx_byte = DEVICE_ID;
      sfd_pkg::OP_MAKER_ID: tx_byte = s_r.id_sel[0] ? DEVICE_ID : MAKER_ID;
      sfd_pkg::OP_JEDEC_ID: begin
        case (s_r.id_sel)
          2'h0: tx_byte = MAKER_ID;
          2'h1: tx_byte = MEM_TYPE;
          default: tx_byte = MEM_CAPACITY;
        endcase
      end
      default: tx_byte = fifo_valid ? fifo_data : sfd_pkg::UNDERRUN_BYTE;
    endcase
  end

  assign fifo_pop = tx_take & s_r.rd_stream;

  // ----------------------------------------------------------------
  // instruction framing
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.sclk_d = i_sclk;
    s_nxt.cs_n_d = i_cs_n;
    s_nxt.exec = 1'b0;
    s_nxt.wr_valid = 1'b0;
    if (i_cycle_done) begin
      s_nxt.busy = 1'b0;
      s_nxt.write_enable_latch = 1'b0;
    end
    if (tx_take && !s_r.rd_stream) begin
      s_nxt.id_sel = (s_r.id_sel == sfd_pkg::JEDEC_LAST) ? '0 : s_r.id_sel + 2'h1;
    end
    if (cs_fall) begin
      s_nxt.phase = sfd_pkg::PH_OPCODE;
      s_nxt.bit_cnt = '0;
      s_nxt.byte_cnt = '0;
      s_nxt.ready_exec = 1'b0;
      s_nxt.rd_stream = 1'b0;
      s_nxt.dual = 1'b0;
      s_nxt.id_sel = '0;
    end else if (cs_rise) begin
      // partial last byte kills a write
      if (s_r.ready_exec && s_r.bit_cnt == '0) begin
        case (s_r.opcode)
          sfd_pkg::OP_WR_ENABLE: s_nxt.write_enable_latch = 1'b1;
          sfd_pkg::OP_WR_DISABLE: s_nxt.write_enable_latch = 1'b0;
          sfd_pkg::OP_POWER_DOWN: s_nxt.pdown = 1'b1;
          sfd_pkg::OP_WR_STATUS: begin
            if (!(s_r.status_lock_bit && !i_wp_n)) begin
              // only lock, tb and bp are written
              s_nxt.status_lock_bit = s_r.new_status[sfd_pkg::ST_LOCK_BIT];
              s_nxt.tb = s_r.new_status[sfd_pkg::ST_TB_BIT];
              s_nxt.bp = s_r.new_status[sfd_pkg::ST_BP_LSB +: 3];
              s_nxt.busy = 1'b1;
              s_nxt.exec = 1'b1;
            end
          end
          default: begin
            s_nxt.busy = 1'b1;
            s_nxt.exec = 1'b1;
          end
        endcase
        s_nxt.exec_op = s_r.opcode;
        s_nxt.exec_addr = s_r.addr;
      end
      s_nxt.phase = sfd_pkg::PH_IDLE;
      s_nxt.ready_exec = 1'b0;
      s_nxt.rd_stream = 1'b0;
      s_nxt.dual = 1'b0;
    end else if (sclk_rise) begin
      s_nxt.shift = byte_in;
      s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
      if (s_r.bit_cnt == sfd_pkg::BIT_LAST) begin
        case (s_r.phase)
          sfd_pkg::PH_OPCODE: begin
            s_nxt.opcode = byte_in;
            s_nxt.phase = sfd_pkg::PH_IGNORE;
            if (s_r.busy && byte_in != sfd_pkg::OP_RD_STATUS) begin
              s_nxt.phase = sfd_pkg::PH_IGNORE;
            end else if (s_r.pdown && byte_in != sfd_pkg::OP_RELEASE_ID
                         && byte_in != sfd_pkg::OP_RD_STATUS) begin
              s_nxt.phase = sfd_pkg::PH_IGNORE;
            end else begin
              case (byte_in)
                sfd_pkg::OP_WR_ENABLE, sfd_pkg::OP_WR_DISABLE,
                sfd_pkg::OP_POWER_DOWN: begin
                  s_nxt.phase = sfd_pkg::PH_WAIT;
                  s_nxt.ready_exec = 1'b1;
                end
                sfd_pkg::OP_RD_STATUS: s_nxt.phase = sfd_pkg::PH_DATA_OUT;
                sfd_pkg::OP_WR_STATUS: begin
                  if (s_r.write_enable_latch) s_nxt.phase = sfd_pkg::PH_DATA_IN;
                end
                sfd_pkg::OP_READ, sfd_pkg::OP_FAST_READ, sfd_pkg::OP_DUAL_READ,
                sfd_pkg::OP_MAKER_ID: s_nxt.phase = sfd_pkg::PH_ADDR;
                sfd_pkg::OP_PROGRAM, sfd_pkg::OP_BLOCK_ERASE,
                sfd_pkg::OP_SECTOR_ERASE: begin
                  if (s_r.write_enable_latch) s_nxt.phase = sfd_pkg::PH_ADDR;
                end
                sfd_pkg::OP_CHIP_ERASE_A, sfd_pkg::OP_CHIP_ERASE_B: begin
                  if (s_r.write_enable_latch) begin
                    s_nxt.phase = sfd_pkg::PH_WAIT;
                    s_nxt.ready_exec = 1'b1;
                  end
                end
                sfd_pkg::OP_RELEASE_ID: begin
                  s_nxt.pdown = 1'b0;
                  s_nxt.phase = sfd_pkg::PH_DUMMY;
                end
                sfd_pkg::OP_JEDEC_ID: s_nxt.phase = sfd_pkg::PH_DATA_OUT;
                default: s_nxt.phase = sfd_pkg::PH_IGNORE;
              endcase
            end
          end
          sfd_pkg::PH_ADDR: begin
            s_nxt.addr = {s_r.addr[15:0], byte_in};
            s_nxt.byte_cnt = s_r.byte_cnt + 2'h1;
            if (s_r.byte_cnt == sfd_pkg::ADDR_LAST) begin
              s_nxt.byte_cnt = '0;
              case (s_r.opcode)
                sfd_pkg::OP_READ: begin
                  s_nxt.phase = sfd_pkg::PH_DATA_OUT;
                  s_nxt.rd_stream = 1'b1;
                end
                sfd_pkg::OP_FAST_READ, sfd_pkg::OP_DUAL_READ: begin
                  s_nxt.phase = sfd_pkg::PH_DUMMY;
                end
                sfd_pkg::OP_PROGRAM: s_nxt.phase = sfd_pkg::PH_DATA_IN;
                sfd_pkg::OP_MAKER_ID: s_nxt.phase = sfd_pkg::PH_DATA_OUT;
                default: begin
                  s_nxt.phase = sfd_pkg::PH_WAIT;
                  s_nxt.ready_exec = 1'b1;
                end
              endcase
            end
          end
          sfd_pkg::PH_DUMMY: begin
            s_nxt.byte_cnt = s_r.byte_cnt + 2'h1;
            if (s_r.opcode != sfd_pkg::OP_RELEASE_ID) begin
              s_nxt.phase = sfd_pkg::PH_DATA_OUT;
              s_nxt.rd_stream = 1'b1;
              s_nxt.dual = (s_r.opcode == sfd_pkg::OP_DUAL_READ);
            end else if (s_r.byte_cnt == sfd_pkg::ID_DUMMY_LAST) begin
              s_nxt.phase = sfd_pkg::PH_DATA_OUT;
            end
          end
          sfd_pkg::PH_DATA_IN: begin
            s_nxt.ready_exec = 1'b1;
            if (s_r.opcode == sfd_pkg::OP_WR_STATUS) begin
              s_nxt.new_status = byte_in & sfd_pkg::ST_WRITABLE_MASK;
              s_nxt.phase = sfd_pkg::PH_WAIT;
            end else begin
              s_nxt.wr_data = byte_in;
              s_nxt.wr_valid = 1'b1;
              s_nxt.wr_addr = s_r.addr;
              s_nxt.addr = {s_r.addr[23:8], s_r.addr[7:0] + 8'h01};
            end
          end
          default: s_nxt.phase = s_r.phase;
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      s_r <= '0;
      s_r.phase <= sfd_pkg::PH_IDLE;
      s_r.cs_n_d <= 1'b1;
      s_r.status_lock_bit <= sfd_pkg::ST_NV_RESET[sfd_pkg::ST_LOCK_BIT];
      s_r.tb <= sfd_pkg::ST_NV_RESET[sfd_pkg::ST_TB_BIT];
      s_r.bp <= sfd_pkg::ST_NV_RESET[sfd_pkg::ST_BP_LSB +: 3];
      s_r.write_enable_latch <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read data buffer and output shifter
  // ----------------------------------------------------------------
  sfd_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_rd_fifo (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_flush(~s_r.rd_stream),
    .i_in_valid(i_rd_valid & s_r.rd_stream),
    .o_in_ready(fifo_in_ready),
    .i_in_data(i_rd_data),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_data)
  );

  sfd_tx_shift u_tx (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_restart(cs_fall),
    .i_step(tx_step),
    .i_dual(s_r.dual),
    .i_byte(tx_byte),
    .o_take(tx_take),
    .o_do(o_serial_data_out),
    .o_dio(o_serial_data_io_out)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_rd_ready = fifo_in_ready & s_r.rd_stream;
  assign o_serial_data_out_oe_n = ~out_phase;
  assign o_serial_data_io_oe_n = ~(out_phase & s_r.dual);
  assign o_rd_stream = s_r.rd_stream;
  assign o_rd_addr = s_r.addr;
  assign o_exec = s_r.exec;
  assign o_exec_op = s_r.exec_op;
  assign o_exec_addr = s_r.exec_addr;
  assign o_wr_valid = s_r.wr_valid;
  assign o_wr_data = s_r.wr_data;
  assign o_wr_addr = s_r.wr_addr;
  assign o_status = status;
  assign o_power_down = s_r.pdown;
endmodule

/* dv/sfd_decoder_monitor.sv */
/*
 * sfd_chk: port assertions for sfd_decoder.
 * assumes: bound to every sfd_decoder, one clock, async high reset.
 */
`timescale 1ns/1ps
module sfd_chk (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_cycle_done,
  input wire logic o_serial_data_out,
  input wire logic o_serial_data_out_oe_n,
  input wire logic o_serial_data_io_oe_n,
  input wire logic o_exec,
  input wire logic o_wr_valid,
  input wire logic o_rd_stream,
  input wire logic o_rd_ready,
  input wire logic [7:0] o_status
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_exec_cs_high: assert property (o_exec |-> i_cs_n && $past(i_cs_n))
    else $error("exec while selected");
  a_exec_sets_busy: assert property (o_exec |-> ##[0:1] o_status[0])
    else $error("exec without busy");
  a_done_clears: assert property (i_cycle_done && o_status[0] |=> o_status[1:0] == 2'h0)
    else $error("done left busy or latch");
  a_busy_holds: assert property (o_status[0] && !i_cycle_done |=> o_status[0])
    else $error("busy dropped early");
  a_wel_set_idle: assert property ($rose(o_status[1]) |-> i_cs_n && !o_status[0])
    else $error("latch set out of turn");
  a_reserved_low: assert property (o_status[6] == 1'h0)
    else $error("reserved status bit set");
  a_oe_idle: assert property (i_cs_n && $past(i_cs_n) && $past(i_cs_n, 2)
    |-> o_serial_data_out_oe_n)
    else $error("output driven while deselected");
  a_out_on_fall: assert property (!o_serial_data_out_oe_n && $past(!o_serial_data_out_oe_n)
    && $changed(o_serial_data_out)
    |-> !$past(i_sclk) && ($past(i_sclk, 2) || $past(i_sclk, 3)))
    else $error("output moved off a falling edge");
  a_io_in_dual: assert property (!o_serial_data_io_oe_n |-> !o_serial_data_out_oe_n)
    else $error("io driven outside data phase");
  a_wr_after_rise: assert property (o_wr_valid |-> $past(i_sclk) && !$past(i_cs_n))
    else $error("write byte off a rising edge");
  a_ready_stream: assert property (o_rd_ready |-> o_rd_stream)
    else $error("fifo ready while not streaming");
  c_exec: cover property (o_exec);
  c_wr: cover property (o_wr_valid);
  c_dual: cover property (!o_serial_data_io_oe_n);
endmodule
bind sfd_decoder sfd_chk i_sfd_chk (.i_sys_clk, .i_reset, .i_cs_n, .i_sclk, .i_cycle_done,
  .o_serial_data_out, .o_serial_data_out_oe_n, .o_serial_data_io_oe_n, .o_exec,
  .o_wr_valid, .o_rd_stream, .o_rd_ready, .o_status);

/* dv/sfd_spi_host.sv */
/*
 * sfd_spi_host: serial host model, clock parked low, 3 clocks a phase.
 * assumes: driven from tb tasks; changes pins at falling i_sys_clk.
 */
`timescale 1ns/1ps
module sfd_spi_host (
  input wire logic i_sys_clk,
  input wire logic i_miso,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_mosi
);
  initial begin
    o_cs_n = 1'h1;
    o_sclk = 1'h0;
    o_mosi = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic start();
    tick(1);
    o_cs_n = 1'h0;
    tick(3);
  endtask
  // n bits msb first, data set in low phase, answer read at rise
  task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] q);
    q = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      o_sclk = 1'h0;
      o_mosi = d[i];
      tick(3);
      o_sclk = 1'h1;
      q[i] = i_miso;
      tick(3);
    end
  endtask
  task automatic stop();
    o_sclk = 1'h0;
    tick(3);
    o_cs_n = 1'h1;
    o_mosi = ~o_mosi;
    tick(4);
  endtask
endmodule

/* dv/tb.sv */
/*
 * tb: self-checking bench for sfd_decoder with a status model and queues.
 * assumes: sfd_spi_host on the serial side, bench plays the array side.
 */
`timescale 1ns/1ps
module tb;
  logic clk, rst, wp_n, done, rd_valid, dout, dout_oe_n, io_oe_n, exec;
  logic wr_valid, rd_stream, rd_ready, pd;
  logic [7:0] rd_data, exec_op, status, st_m, r_b, d;
  logic [23:0] rd_addr, a;
  wire logic cs_n, sclk, mosi, miso;
  int err_total, n_tests, ex_n, ex_e, wr_n, seed;
  logic [7:0] q_exp[$];
  logic [7:0] ops[5] = '{8'h02, 8'h20, 8'hD8, 8'hC7, 8'h60};
  assign miso = dout_oe_n ? ~mosi : dout;
  // arbitrary id values
  sfd_decoder #(.DEVICE_ID(8'h5A), .MAKER_ID(8'hA5), .MEM_TYPE(8'h6E),
    .MEM_CAPACITY(8'h2D), .FIFO_DEPTH(8)) i_sfd_decoder (
    .i_sys_clk(clk), .i_reset(rst), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_serial_data_in(mosi), .i_wp_n(wp_n), .o_serial_data_out(dout),
    .o_serial_data_out_oe_n(dout_oe_n), .o_serial_data_io_out(),
    .o_serial_data_io_oe_n(io_oe_n), .i_cycle_done(done), .o_exec(exec),
    .o_exec_op(exec_op), .o_exec_addr(), .o_wr_valid(wr_valid), .o_wr_data(),
    .o_wr_addr(), .o_rd_stream(rd_stream), .o_rd_addr(rd_addr),
    .i_rd_valid(rd_valid), .o_rd_ready(rd_ready), .i_rd_data(rd_data),
    .o_status(status), .o_power_down(pd));
  sfd_spi_host i_sfd_spi_host (.i_sys_clk(clk), .i_miso(miso), .o_cs_n(cs_n),
    .o_sclk(sclk), .o_mosi(mosi));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic x8(input logic [7:0] v);
    i_sfd_spi_host.xfer(v, 8, r_b);
  endtask
  task automatic drain();
    while (q_exp.size() > 0) begin
      x8(8'h00);
      chk(r_b, q_exp.pop_front());
    end
  endtask
  task automatic frame_rd(input logic [7:0] op, input int nd);
    i_sfd_spi_host.start();
    x8(op);
    repeat (nd) x8(8'h00);
    drain();
    i_sfd_spi_host.stop();
  endtask
  task automatic rdsr(input int n);
    repeat (n) q_exp.push_back(st_m);
    frame_rd(sfd_pkg::OP_RD_STATUS, 0);
  endtask
  task automatic wsr(input logic [7:0] v);
    i_sfd_spi_host.start();
    x8(sfd_pkg::OP_WR_STATUS);
    x8(v);
    i_sfd_spi_host.stop();
  endtask
  task automatic cyc_done();
    rdsr(1);
    @(negedge clk);
    done = 1'h1;
    @(negedge clk);
    done = 1'h0;
    st_m[1:0] = 2'h0;
    @(negedge clk);
    chk(status, st_m);
  endtask
  always @(posedge clk) begin
    if (exec === 1'h1) ex_n++;
    if (wr_valid === 1'h1) wr_n++;
  end
  // ----------------------------------------------------------------
  // run
  // ----------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // whole run is some 5k clocks
  initial begin
    #400000;
    err_total++;
    $display("Error at %0t: watchdog", $time);
    tally_and_finish();
  end
  initial begin
    seed = 73;
    rst = 1'h1;
    wp_n = 1'h1;
    done = 1'h0;
    rd_valid = 1'h0;
    rd_data = 8'h00;
    st_m = 8'h00;
    repeat (16) @(negedge clk);
    rst = 1'h0;
    repeat (2) @(negedge clk);
    chk(status, 8'h00);
    chk({dout_oe_n, io_oe_n}, 2'h3);
    rdsr(2);
    frame_rd(sfd_pkg::OP_WR_ENABLE, 0);
    st_m[1] = 1'h1;
    rdsr(2);
    frame_rd(sfd_pkg::OP_WR_DISABLE, 0);
    st_m[1] = 1'h0;
    d = $random(seed) | 8'h80;
    wsr(d);
    rdsr(1);
    chk(ex_n, ex_e);
    frame_rd(sfd_pkg::OP_WR_ENABLE, 0);
    wsr(d);
    ex_e++;
    st_m = (d & sfd_pkg::ST_WRITABLE_MASK) | 8'h03;
    chk({ex_n, exec_op}, {ex_e, sfd_pkg::OP_WR_STATUS});
    frame_rd(sfd_pkg::OP_WR_DISABLE, 0);
    rdsr(2);
    cyc_done();
    wp_n = 1'h0;
    frame_rd(sfd_pkg::OP_WR_ENABLE, 0);
    st_m[1] = 1'h1;
    wsr(~d);
    rdsr(1);
    chk(ex_n, ex_e);
    wp_n = 1'h1;
    i_sfd_spi_host.start();
    x8(sfd_pkg::OP_PROGRAM);
    repeat (3) x8($random(seed));
    i_sfd_spi_host.xfer(8'hA5, 4, r_b);
    i_sfd_spi_host.stop();
    rdsr(1);
    chk({ex_n, wr_n}, {ex_e, 32'd0});
    foreach (ops[k]) begin
      frame_rd(sfd_pkg::OP_WR_ENABLE, 0);
      i_sfd_spi_host.start();
      x8(ops[k]);
      if (ops[k] != 8'hC7 && ops[k] != 8'h60) repeat (3) x8($random(seed));
      if (ops[k] == 8'h02) x8($random(seed));
      i_sfd_spi_host.stop();
      ex_e++;
      st_m = st_m | 8'h03;
      chk({ex_n, exec_op}, {ex_e, ops[k]});
      cyc_done();
    end
    chk(wr_n, 1);
    frame_rd(sfd_pkg::OP_POWER_DOWN, 0);
    chk(pd, 1'h1);
    frame_rd(sfd_pkg::OP_WR_ENABLE, 0);
    rdsr(1);
    frame_rd(sfd_pkg::OP_RELEASE_ID, 0);
    chk(pd, 1'h0);
    q_exp = '{8'h5A, 8'h5A};
    frame_rd(sfd_pkg::OP_RELEASE_ID, 3);
    q_exp = '{8'hA5, 8'h6E, 8'h2D, 8'hA5};
    frame_rd(sfd_pkg::OP_JEDEC_ID, 0);
    q_exp = '{8'hA5, 8'h5A, 8'hA5};
    frame_rd(sfd_pkg::OP_MAKER_ID, 3);
    a = $random(seed);
    i_sfd_spi_host.start();
    x8(sfd_pkg::OP_READ);
    x8(a[23:16]);
    x8(a[15:8]);
    x8(a[7:0]);
    chk({rd_stream, rd_addr}, {1'h1, a});
    for (int k = 0; k < 12; k++) begin
      @(negedge clk);
      rd_valid = rd_ready;
      rd_data = $random(seed);
      if (rd_ready === 1'h1) q_exp.push_back(rd_data);
    end
    rd_valid = 1'h0;
    chk(q_exp.size(), 8);
    q_exp.push_back(sfd_pkg::UNDERRUN_BYTE);
    drain();
    i_sfd_spi_host.stop();
    i_sfd_spi_host.start();
    x8(sfd_pkg::OP_DUAL_READ);
    repeat (4) x8($random(seed));
    i_sfd_spi_host.xfer(8'h00, 2, r_b);
    chk(io_oe_n, 1'h0);
    i_sfd_spi_host.stop();
    tally_and_finish();
  end
endmodule
